// [core/mas_axil.sv]
`timescale 1ns/1ns
// AXI4-Lite slave holding the slice configuration and showing its state
module mas_axil
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [mas_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [mas_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // slice side
  mas_cfg_if.bus cfg
);
  logic aw_held, w_held, ws_q, next_aw_held, next_w_held, next_ws;
  logic [mas_pkg::ADDR_W-1:0] aw_q, next_aw_q;
  logic [7:0] wd_q, next_wd, cfg_q, next_cfg;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // configuration fields fan out to the core
  assign cfg.split = cfg_q[mas_pkg::CFG_SPLIT];
  assign cfg.mode = mas_pkg::mas_mode_t'(cfg_q[mas_pkg::CFG_MODE_HI:mas_pkg::CFG_MODE_LO]);
  assign cfg.in_byp = cfg_q[mas_pkg::CFG_IN_BYP];
  assign cfg.mid_byp = cfg_q[mas_pkg::CFG_MID_BYP];
  assign cfg.out_byp = cfg_q[mas_pkg::CFG_OUT_BYP];
  assign cfg.chain_sel = cfg_q[mas_pkg::CFG_CHAIN];
  assign cfg.casc = cfg_q[mas_pkg::CFG_CASC];

  // address and data are taken in either order, write done once both held
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_q = aw_q;
    next_wd = wd_q;
    next_ws = ws_q;
    next_cfg = cfg_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_wd = s_axi_wdata[7:0];
      next_ws = s_axi_wstrb[0];
    end
    if (aw_held && w_held && !s_axi_bvalid)
    begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mas_pkg::RESP_SLVERR;
      if (aw_q == mas_pkg::CFG_OFS)
      begin
        next_bresp = mas_pkg::RESP_OKAY;
        if (ws_q)
          next_cfg = wd_q;
      end
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
    // reads answer from the registered state of the slice
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = mas_pkg::RESP_OKAY;
      case (s_axi_araddr)
        mas_pkg::CFG_OFS: next_rdata = {24'h000000, cfg_q};
        mas_pkg::RES_OFS: next_rdata = cfg.result;
        mas_pkg::FLG_OFS: next_rdata = {29'h00000000, cfg.flags};
        default:
        begin
          next_rdata = 32'h00000000;
          next_rresp = mas_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
    // one transfer of each kind at a time
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // bus state registers
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 4'h0;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
      cfg_q <= mas_pkg::CFG_RST;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_q <= next_aw_q;
      wd_q <= next_wd;
      ws_q <= next_ws;
      cfg_q <= next_cfg;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end
endmodule

// [core/mas_cfg_if.sv]
`timescale 1ns/1ns
// configuration and status carried between register slave and slice core
interface mas_cfg_if;
  logic split;
  mas_pkg::mas_mode_t mode;
  logic in_byp;
  logic mid_byp;
  logic out_byp;
  logic chain_sel;
  logic casc;
  logic [31:0] result;
  logic [2:0] flags;
  modport bus (output split, mode, in_byp, mid_byp, out_byp, chain_sel, casc,
    input result, flags);
  modport core (input split, mode, in_byp, mid_byp, out_byp, chain_sel, casc,
    output result, flags);
endinterface

// [core/mas_half.sv]
`timescale 1ns/1ns
// one accumulator half: adder/subtracter with load, clear and freeze
module mas_half #(parameter int W = 16)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // controls
  input wire logic en,
  input wire logic clear,
  input wire logic freeze,
  input wire logic load_sel,
  input wire logic sub_sel,
  input wire logic use_acc,
  // operands
  input wire logic [W-1:0] base,
  input wire logic [W-1:0] addend,
  input wire logic [W-1:0] load_val,
  input wire logic cin,
  // results
  output logic [W-1:0] acc,
  output logic [W-1:0] sum,
  output logic [W-1:0] next_acc,
  output logic cout
);
  logic [W-1:0] op;
  logic [W:0] raw;

  // subtract as op + ~addend + ~borrow; carry out turns into borrow out
  always_comb
  begin
    op = use_acc ? acc : base;
    raw = {1'b0, op} + {1'b0, addend ^ {W{sub_sel}}} + {{W{1'b0}}, cin ^ sub_sel}; // see [RULE_11]
    sum = raw[W-1:0];
    cout = raw[W] ^ sub_sel;
    next_acc = acc;
    if (en) // see [RULE_01]
    begin
      if (clear) // see [RULE_09]
        next_acc = {W{1'b0}};
      else if (freeze) // see [RULE_20]
        next_acc = acc;
      else if (load_sel) // see [RULE_10]
        next_acc = load_val;
      else
        next_acc = sum; // see [RULE_08]
    end
  end

  // accumulator register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      acc <= {W{1'b0}};
    else
      acc <= next_acc;
  end

  AST_SUB_RESULT: assert property (@(posedge ref_clk) disable iff (!resetn) // see [RULE_11]
    en && !clear && !freeze && !load_sel && sub_sel
    |=> acc == $past(op) - $past(addend) - {{(W-1){1'b0}}, $past(cin)})
    else $error("subtract result wrong");

  AST_CLEAR_WINS: assert property (@(posedge ref_clk) disable iff (!resetn) // see [RULE_20]
    en && clear && freeze |=> acc == {W{1'b0}})
    else $error("clear did not beat freeze");
endmodule

// [core/mas_pkg.sv]
// shared constants and types for the multiply-accumulate slice
package mas_pkg;
  // register port address width and word offsets
  localparam int ADDR_W = 4;
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] RES_OFS = 4'h4;
  localparam logic [3:0] FLG_OFS = 4'h8;
  // configuration word field positions
  localparam int CFG_SPLIT = 0;
  localparam int CFG_MODE_LO = 1;
  localparam int CFG_MODE_HI = 2;
  localparam int CFG_IN_BYP = 3;
  localparam int CFG_MID_BYP = 4;
  localparam int CFG_OUT_BYP = 5;
  localparam int CFG_CHAIN = 6;
  localparam int CFG_CASC = 7;
  // value of the configuration word after reset
  localparam logic [7:0] CFG_RST = 8'h00;
  // bus response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // datapath function of the slice
  typedef enum logic [1:0] {MAS_MUL, MAS_ADD, MAS_ACC, MAS_MAC} mas_mode_t;
endpackage

// [core/mas_slice.sv]
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
// multiply-accumulate slice top: operand registers, multipliers, accumulators
// What this block does
// [RULE_01] all registers use ref_clk and advance only while clk_en_signal is 1; the register slave flops here ignore clk_en_signal
// [RULE_02] operands A and B are 16 bits, registered, feed multiplier or adder
// [RULE_03] operands C and D are 16 bits, registered, feed only the adder
// [RULE_04] each operand register has a freeze: 0 updates, 1 keeps contents
// [RULE_05] upper input clear zeroes A, C and upper multiplier pipeline register
// [RULE_06] lower input clear zeroes B, D, lower and full product registers
// [RULE_07] result is the full 32-bit answer, or upper and lower 16-bit halves
// [RULE_08] each accumulator half has a freeze: 0 updates, 1 keeps contents
// [RULE_09] each accumulator half has a clear: 1 zeroes that half
// [RULE_10] load select 0 takes the adder result, 1 takes operand C
// [RULE_11] subtract select 0 adds, 1 subtracts, per half
// [RULE_12] chain carry/borrow comes from the previous slice, goes to the next
// [RULE_13] tile carry/borrow comes from fabric below, goes to fabric above
// [RULE_14] sign extension comes from the previous slice, goes to the next
// [RULE_15] multiplier, adder/subtracter, accumulator or MAC, split or full width
// [RULE_16] unconnected operands are zero, tied off by the surrounding logic
// [RULE_17] input, product and output registers are each bypassable; the output bypass here picks the adder sum, result_out stays registered
// [RULE_18] in split mode the two halves work fully independently
// [RULE_19] split upper multiplier takes upper bytes, lower takes lower bytes
// [RULE_20] clears and freezes are synchronous; clear beats freeze
module mas_slice #(parameter int W = 16)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // AXI4-Lite write channels
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [mas_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read channels
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [mas_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // slice enable
  input wire logic clk_en_signal,
  // operands
  input wire logic [W-1:0] operand_a,
  input wire logic [W-1:0] operand_b,
  input wire logic [W-1:0] operand_c,
  input wire logic [W-1:0] operand_d,
  // operand register controls
  input wire logic operand_a_freeze,
  input wire logic operand_b_freeze,
  input wire logic operand_c_freeze,
  input wire logic operand_d_freeze,
  input wire logic upper_input_clear,
  input wire logic lower_input_clear,
  // accumulator controls
  input wire logic upper_acc_freeze,
  input wire logic upper_acc_clear,
  input wire logic upper_acc_load_sel,
  input wire logic upper_sub_sel,
  input wire logic lower_acc_freeze,
  input wire logic lower_acc_clear,
  input wire logic lower_acc_load_sel,
  input wire logic lower_sub_sel,
  // neighbour chains
  input wire logic chain_carry_in,
  output logic chain_carry_out,
  input wire logic tile_carry_in,
  output logic tile_carry_out,
  input wire logic chain_sign_in,
  output logic chain_sign_out,
  // result
  output logic [2*W-1:0] result_out
);
  localparam int H = W / 2;

  // config and status shared with the register slave
  mas_cfg_if cfg_bus ();

  // operand, product and accumulator state
  logic [W-1:0] a_q, b_q, c_q, d_q;
  logic [W-1:0] next_a, next_b, next_c, next_d;
  logic [W-1:0] a_op, b_op, c_op, d_op;
  logic [W-1:0] mul_top, mul_bot, mid_top, mid_bot;
  logic [W-1:0] prod_top, prod_bot, next_prod_top, next_prod_bot;
  logic [2*W-1:0] mul_full, mid_full, prod_full, next_prod_full;
  logic use_acc, use_mul;
  logic [W-1:0] base_hi, base_lo, add_hi, add_lo;
  logic [W-1:0] acc_hi, acc_lo, sum_hi, sum_lo, nacc_hi, nacc_lo;
  logic cout_hi, cout_lo, cin_hi, cin_lo;
  logic upd_hi, upd_lo;
  logic [2*W-1:0] next_result;
  logic next_chain_cout, next_tile_cout, next_sign;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // register slave
  mas_axil u_regs
  (
    .ref_clk (ref_clk),
    .resetn (resetn),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_awaddr (s_axi_awaddr),
    .s_axi_wvalid (s_axi_wvalid),
    .s_axi_wready (s_axi_wready),
    .s_axi_wdata (s_axi_wdata),
    .s_axi_wstrb (s_axi_wstrb),
    .s_axi_bvalid (s_axi_bvalid),
    .s_axi_bready (s_axi_bready),
    .s_axi_bresp (s_axi_bresp),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_araddr (s_axi_araddr),
    .s_axi_rvalid (s_axi_rvalid),
    .s_axi_rready (s_axi_rready),
    .s_axi_rdata (s_axi_rdata),
    .s_axi_rresp (s_axi_rresp),
    .cfg (cfg_bus)
  );

  // status seen by software comes from output flops only
  assign cfg_bus.result = result_out;
  assign cfg_bus.flags = {chain_carry_out, tile_carry_out, chain_sign_out};

  // mode decode: what feeds the adder and what it adds to
  always_comb
  begin
    unique case (cfg_bus.mode) // see [RULE_15]
      mas_pkg::MAS_MUL:
      begin
        use_mul = 1'b1;
        use_acc = 1'b0;
      end
      mas_pkg::MAS_ADD:
      begin
        use_mul = 1'b0;
        use_acc = 1'b0;
      end
      mas_pkg::MAS_ACC:
      begin
        use_mul = 1'b0;
        use_acc = 1'b1;
      end
      mas_pkg::MAS_MAC:
      begin
        use_mul = 1'b1;
        use_acc = 1'b1;
      end
    endcase
  end

  // operand registers; a clear beats a freeze, nothing moves while disabled
  always_comb
  begin
    next_a = a_q;
    next_b = b_q;
    next_c = c_q;
    next_d = d_q;
    if (clk_en_signal) // see [RULE_01]
    begin
      if (upper_input_clear) // see [RULE_05]
      begin
        next_a = {W{1'b0}};
        next_c = {W{1'b0}};
      end
      else
      begin
        if (!operand_a_freeze) // see [RULE_04]
          next_a = operand_a; // see [RULE_02]
        if (!operand_c_freeze)
          next_c = operand_c; // see [RULE_03]
      end
      if (lower_input_clear) // see [RULE_06]
      begin
        next_b = {W{1'b0}};
        next_d = {W{1'b0}};
      end
      else
      begin
        if (!operand_b_freeze)
          next_b = operand_b;
        if (!operand_d_freeze)
          next_d = operand_d;
      end
    end
  end

  // operand register flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      a_q <= {W{1'b0}};
      b_q <= {W{1'b0}};
      c_q <= {W{1'b0}};
      d_q <= {W{1'b0}};
    end
    else
    begin
      a_q <= next_a;
      b_q <= next_b;
      c_q <= next_c;
      d_q <= next_d;
    end
  end

  // input bypass trades a cycle of latency against a longer path
  assign a_op = cfg_bus.in_byp ? operand_a : a_q; // see [RULE_17]
  assign b_op = cfg_bus.in_byp ? operand_b : b_q;
  assign c_op = cfg_bus.in_byp ? operand_c : c_q;
  assign d_op = cfg_bus.in_byp ? operand_d : d_q;

  // byte multipliers and the full multiplier, zero-extended to full width
  assign mul_top = {{H{1'b0}}, a_op[W-1:H]} * {{H{1'b0}}, b_op[W-1:H]}; // see [RULE_19]
  assign mul_bot = {{H{1'b0}}, a_op[H-1:0]} * {{H{1'b0}}, b_op[H-1:0]};
  assign mul_full = {{W{1'b0}}, a_op} * {{W{1'b0}}, b_op};

  // product pipeline registers with their section clears
  always_comb
  begin
    next_prod_top = prod_top;
    next_prod_bot = prod_bot;
    next_prod_full = prod_full;
    if (clk_en_signal)
    begin
      next_prod_top = upper_input_clear ? {W{1'b0}} : mul_top; // see [RULE_05]
      next_prod_bot = lower_input_clear ? {W{1'b0}} : mul_bot; // see [RULE_06]
      next_prod_full = lower_input_clear ? {(2*W){1'b0}} : mul_full;
    end
  end

  // product register flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prod_top <= {W{1'b0}};
      prod_bot <= {W{1'b0}};
      prod_full <= {(2*W){1'b0}};
    end
    else
    begin
      prod_top <= next_prod_top;
      prod_bot <= next_prod_bot;
      prod_full <= next_prod_full;
    end
  end

  // product bypass skips the intermediate stage
  assign mid_top = cfg_bus.mid_byp ? mul_top : prod_top; // see [RULE_17]
  assign mid_bot = cfg_bus.mid_byp ? mul_bot : prod_bot;
  assign mid_full = cfg_bus.mid_byp ? mul_full : prod_full;

  // adder operand steering; C and D never reach a multiplier
  always_comb
  begin
    cin_lo = cfg_bus.chain_sel ? chain_carry_in : tile_carry_in; // see [RULE_12] [RULE_13]
    base_hi = (cfg_bus.mode == mas_pkg::MAS_ADD) ? c_op : {W{1'b0}}; // see [RULE_03]
    base_lo = (cfg_bus.mode == mas_pkg::MAS_ADD) ? d_op : {W{1'b0}};
    if (cfg_bus.split)
    begin
      // no carry crosses the middle, so the halves stay independent
      cin_hi = 1'b0; // see [RULE_18]
      add_hi = use_mul ? mid_top : a_op; // see [RULE_02]
      add_lo = use_mul ? mid_bot : b_op;
    end
    else if (cfg_bus.casc)
    begin
      // upper slice of a wide sum adds the sign fill of the lower addend
      cin_hi = cout_lo;
      add_hi = {W{chain_sign_in}}; // see [RULE_14]
      add_lo = {W{chain_sign_in}};
    end
    else
    begin
      cin_hi = cout_lo;
      add_hi = use_mul ? mid_full[2*W-1:W] : a_op;
      add_lo = use_mul ? mid_full[W-1:0] : b_op;
    end
  end

  // upper accumulator half
  mas_half #(.W(W)) u_hi
  (
    .ref_clk (ref_clk),
    .resetn (resetn),
    .en (clk_en_signal),
    .clear (upper_acc_clear),
    .freeze (upper_acc_freeze),
    .load_sel (upper_acc_load_sel),
    .sub_sel (upper_sub_sel),
    .use_acc (use_acc),
    .base (base_hi),
    .addend (add_hi),
    .load_val (c_op),
    .cin (cin_hi),
    .acc (acc_hi),
    .sum (sum_hi),
    .next_acc (nacc_hi),
    .cout (cout_hi)
  );

  // lower accumulator half
  mas_half #(.W(W)) u_lo
  (
    .ref_clk (ref_clk),
    .resetn (resetn),
    .en (clk_en_signal),
    .clear (lower_acc_clear),
    .freeze (lower_acc_freeze),
    .load_sel (lower_acc_load_sel),
    .sub_sel (lower_sub_sel),
    .use_acc (use_acc),
    .base (base_lo),
    .addend (add_lo),
    .load_val (c_op),
    .cin (cin_lo),
    .acc (acc_lo),
    .sum (sum_lo),
    .next_acc (nacc_lo),
    .cout (cout_lo)
  );

  // result and chain outputs; chain bits are sent once per real update,
  // a cycle late, so a neighbour slice runs one cycle behind this one
  always_comb
  begin
    upd_hi = !upper_acc_clear && !upper_acc_freeze && !upper_acc_load_sel;
    upd_lo = !lower_acc_clear && !lower_acc_freeze && !lower_acc_load_sel;
    next_result = result_out;
    next_chain_cout = chain_carry_out;
    next_tile_cout = tile_carry_out;
    next_sign = chain_sign_out;
    if (clk_en_signal)
    begin
      // output bypass shows the raw adder result, ignoring acc controls
      next_result = cfg_bus.out_byp ? {sum_hi, sum_lo} : {nacc_hi, nacc_lo}; // see [RULE_07]
      next_chain_cout = upd_hi && cout_hi; // see [RULE_12]
      next_tile_cout = cfg_bus.split ? (upd_lo && cout_lo) : (upd_hi && cout_hi); // see [RULE_13]
      next_sign = upd_hi && add_hi[W-1]; // see [RULE_14]
    end
  end

  // output flops
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      result_out <= {(2*W){1'b0}};
      chain_carry_out <= 1'b0;
      tile_carry_out <= 1'b0;
      chain_sign_out <= 1'b0;
    end
    else
    begin
      result_out <= next_result;
      chain_carry_out <= next_chain_cout;
      tile_carry_out <= next_tile_cout;
      chain_sign_out <= next_sign;
    end
  end

  // operands taken into registers, then products taken one cycle later
  sequence s_ops_taken;
    clk_en_signal && !operand_a_freeze && !operand_b_freeze
      && !upper_input_clear && !lower_input_clear && !cfg_bus.in_byp;
  endsequence

  sequence s_mid_taken;
    clk_en_signal && !lower_input_clear && !cfg_bus.in_byp;
  endsequence

  AST_EN_STALL: assert property ( // see [RULE_01]
    !clk_en_signal |=> $stable(result_out) && $stable(a_q) && $stable(prod_full)
      && $stable(acc_hi) && $stable(chain_carry_out))
    else $error("state moved while disabled");

  AST_A_CAPTURE: assert property ( // see [RULE_02]
    clk_en_signal && !operand_a_freeze && !upper_input_clear |=> a_q == $past(operand_a))
    else $error("operand a not captured");

  AST_D_FREEZE: assert property ( // see [RULE_04]
    clk_en_signal && operand_d_freeze && !lower_input_clear |=> $stable(d_q))
    else $error("frozen operand d changed");

  AST_UPPER_CLEAR: assert property ( // see [RULE_05]
    clk_en_signal && upper_input_clear |=> a_q == {W{1'b0}} && c_q == {W{1'b0}}
      && prod_top == {W{1'b0}})
    else $error("upper input clear incomplete");

  AST_LOWER_CLEAR: assert property ( // see [RULE_06]
    clk_en_signal && lower_input_clear |=> b_q == {W{1'b0}} && d_q == {W{1'b0}}
      && prod_bot == {W{1'b0}} && prod_full == {(2*W){1'b0}})
    else $error("lower input clear incomplete");

  AST_ACC_FREEZE: assert property ( // see [RULE_08]
    clk_en_signal && lower_acc_freeze && !lower_acc_clear |=> $stable(acc_lo))
    else $error("frozen lower accumulator changed");

  AST_ACC_CLEAR: assert property ( // see [RULE_09]
    clk_en_signal && upper_acc_clear |=> acc_hi == {W{1'b0}})
    else $error("upper accumulator not cleared");

  AST_LOAD_C: assert property ( // see [RULE_10]
    clk_en_signal && !lower_acc_clear && !lower_acc_freeze && lower_acc_load_sel
      |=> acc_lo == $past(c_op))
    else $error("lower accumulator did not load operand c");

  AST_FULL_PRODUCT: assert property ( // see [RULE_15]
    s_ops_taken ##1 s_mid_taken
      |=> prod_full == {{W{1'b0}}, $past(operand_a, 2)} * {{W{1'b0}}, $past(operand_b, 2)})
    else $error("full product pipeline wrong");

  AST_UPPER_BYTES: assert property ( // see [RULE_19]
    clk_en_signal && !upper_input_clear
      |=> prod_top == {{H{1'b0}}, $past(a_op[W-1:H])} * {{H{1'b0}}, $past(b_op[W-1:H])})
    else $error("upper byte product wrong");
endmodule

// [verif/mas_fabric_model.sv]
// fabric neighbour stand-in for the slice chain and tile carries
`timescale 1ns/1ns
module mas_fabric_model
(
  // from the bench, standing in for the tile below
  input wire logic tile_carry_src,
  // from the slice
  input wire logic chain_carry_out,
  input wire logic tile_carry_out,
  input wire logic chain_sign_out,
  // to the slice
  output logic chain_carry_in,
  output logic tile_carry_in,
  output logic chain_sign_in
);
  // head of chain, so nothing comes in from a previous slice
  assign chain_carry_in = 1'b0;
  assign tile_carry_in = tile_carry_src;
  assign chain_sign_in = 1'b0;
endmodule

// [verif/tb.sv]
// self-checking bench for the multiply-accumulate slice
`timescale 1ns/1ns
module tb;
  logic ref_clk = 0, resetn = 0, clk_en_signal = 1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [15:0] operand_a = 16'h0, operand_b = 16'h0, operand_c = 16'h0, operand_d = 16'h0;
  logic operand_a_freeze = 0, operand_b_freeze = 0, operand_c_freeze = 0;
  logic operand_d_freeze = 0, upper_input_clear = 0, lower_input_clear = 0;
  logic upper_acc_freeze = 0, upper_acc_clear = 0, upper_acc_load_sel = 0, upper_sub_sel = 0;
  logic lower_acc_freeze = 0, lower_acc_clear = 0, lower_acc_load_sel = 0, lower_sub_sel = 0;
  logic chain_carry_in, tile_carry_in, chain_sign_in;
  logic tile_carry_src = 0;
  logic chain_carry_out, tile_carry_out, chain_sign_out;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, result_out;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  mas_slice i_mas_slice (.*);
  mas_fabric_model i_mas_fabric_model (.*);
  // free-running 100 ns clock
  always #50 ref_clk = ~ref_clk;
  task chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard, well above the hundred or so cycles the tests need
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end
  // address and data offered together, each dropped once taken
  task wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw && w))
    begin
      @(posedge ref_clk);
      if (s_axi_awready && !aw)
      begin
        aw = 1;
        s_axi_awvalid <= 0;
      end
      if (s_axi_wready && !w)
      begin
        w = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task rd(input logic [3:0] ad, input logic [31:0] e, input logic [1:0] er);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // new operands, then let the three-edge pipeline settle
  task op(input logic [15:0] a, b, c, d);
    operand_a <= a;
    operand_b <= b;
    operand_c <= c;
    operand_d <= d;
    repeat (5) @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    resetn <= 1;
    @(posedge ref_clk);
    rd(mas_pkg::CFG_OFS, 32'h0, mas_pkg::RESP_OKAY);
    rd(4'hC, 32'h0, mas_pkg::RESP_SLVERR);
    wr(mas_pkg::RES_OFS, 32'h1, mas_pkg::RESP_SLVERR);
    op(16'h0102, 16'h0304, 16'h0, 16'h0);
    chk(result_out, 32'h00030A08);
    rd(mas_pkg::RES_OFS, 32'h00030A08, mas_pkg::RESP_OKAY);
    clk_en_signal <= 0;
    op(16'h0005, 16'h0002, 16'h0, 16'h0);
    chk(result_out, 32'h00030A08);
    clk_en_signal <= 1;
    operand_a_freeze <= 1;
    operand_d_freeze <= 1;
    op(16'h0007, 16'h0002, 16'h0, 16'h0009);
    chk(result_out, 32'h00000204);
    upper_input_clear <= 1;
    op(16'h0007, 16'h0002, 16'h0, 16'h0);
    chk(result_out, 32'h0);
    upper_input_clear <= 0;
    operand_a_freeze <= 0;
    operand_d_freeze <= 0;
    wr(mas_pkg::CFG_OFS, 32'h01, mas_pkg::RESP_OKAY);
    op(16'h0302, 16'h0504, 16'h0, 16'h0);
    chk(result_out, 32'h000F0008);
    lower_input_clear <= 1;
    op(16'h0302, 16'h0504, 16'h0, 16'h0);
    chk(result_out, 32'h0);
    lower_input_clear <= 0;
    wr(mas_pkg::CFG_OFS, 32'h02, mas_pkg::RESP_OKAY);
    upper_sub_sel <= 1;
    lower_sub_sel <= 1;
    op(16'h0, 16'h0003, 16'h0, 16'h000A);
    chk(result_out, 32'h00000007);
    upper_sub_sel <= 0;
    lower_sub_sel <= 0;
    op(16'h0, 16'h0003, 16'h0, 16'h000A);
    chk(result_out, 32'h0000000D);
    tile_carry_src <= 1;
    op(16'h0, 16'h0003, 16'h0, 16'h000A);
    chk(result_out, 32'h0000000E);
    tile_carry_src <= 0;
    op(16'hFFFF, 16'hFFFF, 16'h0, 16'h0001);
    chk(result_out, 32'h0);
    rd(mas_pkg::FLG_OFS, 32'h00000007, mas_pkg::RESP_OKAY);
    wr(mas_pkg::CFG_OFS, 32'h05, mas_pkg::RESP_OKAY);
    upper_acc_load_sel <= 1;
    lower_acc_load_sel <= 1;
    op(16'h0, 16'h0, 16'h0011, 16'h0);
    chk(result_out, 32'h00110011);
    upper_acc_clear <= 1;
    upper_acc_freeze <= 1;
    op(16'h0, 16'h0, 16'h0011, 16'h0);
    chk(result_out, 32'h00000011);
    upper_acc_clear <= 0;
    lower_acc_freeze <= 1;
    op(16'h0, 16'h0, 16'h0022, 16'h0);
    chk(result_out, 32'h00000011);
    wr(mas_pkg::CFG_OFS, 32'h06, mas_pkg::RESP_OKAY);
    {upper_acc_load_sel, lower_acc_load_sel, upper_acc_freeze, lower_acc_freeze} <= 4'h0;
    {upper_acc_clear, lower_acc_clear} <= 2'h3;
    op(16'h0001, 16'h0001, 16'h0, 16'h0);
    {upper_acc_clear, lower_acc_clear} <= 2'h0;
    repeat (3) @(posedge ref_clk);
    {upper_acc_freeze, lower_acc_freeze} <= 2'h3;
    repeat (2) @(posedge ref_clk);
    chk(result_out, 32'h00000003);
    tally_and_finish;
  end
endmodule
